/* hw/ata_interface_config.v */
// Purpose: drive interface configuration register on an AXI4-Lite slave
// Assumes: single clock aclk, synchronous active-low aresetn
// Notes: register bit n, numbered msb-first, is bus data bit 31-n
//
// Operation
// - device type bit 0 selects ATA protocol, 1 selects ATAPI protocol.
// - mode code 00 PIO, 01 multiword DMA, 11 ultra DMA; 10 invalid.
// - multiword DMA speed values 0..2 select modes 0..2; 3..7 reserved.
// - ultra DMA speed values 0..4 map up to mode 3; 5..7 reserved.
// - PIO speed values 0..4 select PIO modes 0..4; 5..7 reserved.
// - writing 1 to soft reset bit resets the internal ATA controller.
// - setting hard reset bit issues one 25 us reset pulse to drive.
// - hard reset bit reads set during the pulse, clear when done.
// - direction bit sets data direction across the drive interface.
// - write-only qualifier: 1 runs command, packet (ATAPI only), data; 0 data only.
// - writing trigger starts the sequencer; trigger clears after one cycle.
// - nondata flag 1 means the command has no data phase.
// - all configuration bits are zero after reset.
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ata_cfg_defs.vh"

module ata_interface_config #(
	parameter integer TICK_CYCLES = `TICK_CYCLES,
	parameter integer PULSE_US = `HRST_PULSE_US
) (
	input wire aclk,
	input wire aresetn,
	input wire [`ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg device_type_select,
	output reg [1:0] transfer_mode_code,
	output reg [2:0] dma_speed_sel,
	output reg [2:0] pio_speed_sel,
	output wire mode_pio,
	output wire mode_mwdma,
	output wire mode_udma,
	output wire [2:0] timing_index,
	output reg controller_soft_reset,
	output wire drive_reset_n,
	output reg transfer_dir,
	output reg seq_start,
	output reg seq_cmd_phase,
	output reg seq_packet_phase,
	output reg seq_data_phase
);

// ==========================================
// helpers

// byte-enable to bit mask
function [31:0] lane_mask;
	input [3:0] strb;
	begin
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	end
endfunction

// mode code and speed grade form a usable combination
function cfg_ok;
	input [1:0] tm;
	input [2:0] dma;
	input [2:0] pio;
	begin
		case (tm)
		`TM_PIO: begin
			cfg_ok = (pio <= `PIO_MAX);
		end
		`TM_MWDMA: begin
			cfg_ok = (dma <= `MWDMA_MAX);
		end
		`TM_UDMA: begin
			cfg_ok = (dma <= `UDMA_MAX);
		end
		default: begin
			cfg_ok = 1'b0;
		end
		endcase
	end
endfunction

// ==========================================
// write channel capture

reg aw_full_r;
reg w_full_r;
reg [`ADDR_W-1:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
wire do_write;

// awaddr and wdata may come in either order; the write lands once both are held
assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_full_r <= 1'b0;
		w_full_r <= 1'b0;
		aw_addr_r <= {`ADDR_W{1'b0}};
		w_data_r <= 32'h00000000;
		w_strb_r <= 4'h0;
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OKAY;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		if (do_write) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_r == `CFG_ADDR || aw_addr_r == `STAT_ADDR) ?
				`RESP_OKAY : `RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

// ==========================================
// configuration register

wire cfg_wr;
wire st_wr;
wire [31:0] wmask;
wire [31:0] cfg_cur;
wire [31:0] cfg_new;
wire hrst_busy;
reg hrst_start_r;
reg refused_r;
wire trig_wr;
wire cfg_valid;
wire new_valid;
reg nondata_r;

assign cfg_wr = do_write && (aw_addr_r == `CFG_ADDR);
assign st_wr = do_write && (aw_addr_r == `STAT_ADDR);
assign wmask = lane_mask(w_strb_r);
assign cfg_valid = cfg_ok(transfer_mode_code, dma_speed_sel, pio_speed_sel);

// current stored value laid out on the bus, write-only bits as zero
assign cfg_cur = {device_type_select, 1'b0, transfer_mode_code, 5'h00, dma_speed_sel,
	1'b0, pio_speed_sel, controller_soft_reset, 1'b0, 1'b0, transfer_dir, 1'b0,
	1'b0, 1'b0, nondata_r, 8'h00};
assign cfg_new = (cfg_cur & ~wmask) | (w_data_r & wmask);
assign trig_wr = cfg_wr && cfg_new[`POS_TRIGGER];
assign new_valid = cfg_ok(cfg_new[`POS_TM_HI:`POS_TM_LO],
	cfg_new[`POS_DMA_HI:`POS_DMA_LO], cfg_new[`POS_PIO_HI:`POS_PIO_LO]);

always @(posedge aclk) begin
	if (!aresetn) begin
		device_type_select <= 1'b0;
		transfer_mode_code <= `TM_PIO;
		dma_speed_sel <= 3'h0;
		pio_speed_sel <= 3'h0;
		controller_soft_reset <= 1'b0;
		transfer_dir <= 1'b0;
		nondata_r <= 1'b0;
		hrst_start_r <= 1'b0;
	end else begin
		hrst_start_r <= 1'b0;
		if (cfg_wr) begin
			// reserved positions never reach storage
			device_type_select <= cfg_new[`POS_DEV_TYPE];
			transfer_mode_code <= cfg_new[`POS_TM_HI:`POS_TM_LO];
			dma_speed_sel <= cfg_new[`POS_DMA_HI:`POS_DMA_LO];
			pio_speed_sel <= cfg_new[`POS_PIO_HI:`POS_PIO_LO];
			controller_soft_reset <= cfg_new[`POS_SOFT_RST];
			transfer_dir <= cfg_new[`POS_DIR];
			nondata_r <= cfg_new[`POS_NONDATA];
			// a second pulse request while one runs is dropped
			hrst_start_r <= wmask[`POS_HARD_RST] && w_data_r[`POS_HARD_RST] &&
				!hrst_busy;
		end
	end
end

// ==========================================
// sequencer trigger; refused while in soft reset, in hard reset or misconfigured

wire trig_ok;

assign trig_ok = new_valid && !cfg_new[`POS_SOFT_RST] && !hrst_busy && !hrst_start_r;

always @(posedge aclk) begin
	if (!aresetn) begin
		seq_start <= 1'b0;
		seq_cmd_phase <= 1'b0;
		seq_packet_phase <= 1'b0;
		seq_data_phase <= 1'b0;
		refused_r <= 1'b0;
	end else begin
		seq_start <= trig_wr && trig_ok;
		if (trig_wr && trig_ok) begin
			// qualifier is sampled with the trigger and never stored for readback
			seq_cmd_phase <= cfg_new[`POS_AUTO_CMD];
			seq_packet_phase <= cfg_new[`POS_AUTO_CMD] && cfg_new[`POS_DEV_TYPE];
			seq_data_phase <= !cfg_new[`POS_NONDATA];
		end
		// set wins over a same-cycle clear
		if (trig_wr && !trig_ok) begin
			refused_r <= 1'b1;
		end else if (st_wr && wmask[`POS_ST_REFUSED] && w_data_r[`POS_ST_REFUSED]) begin
			refused_r <= 1'b0;
		end
	end
end

// ==========================================
// drive hard reset pulse

hard_reset_pulse #(
	.TICK_CYCLES(TICK_CYCLES),
	.PULSE_US(PULSE_US)
) u_hrst (
	.aclk(aclk),
	.aresetn(aresetn),
	.start(hrst_start_r),
	.busy(hrst_busy),
	.drive_reset_n(drive_reset_n)
);

// ==========================================
// mode and timing decode

speed_decode u_dec (
	.aclk(aclk),
	.aresetn(aresetn),
	.transfer_mode_code(transfer_mode_code),
	.dma_speed_sel(dma_speed_sel),
	.pio_speed_sel(pio_speed_sel),
	.mode_pio(mode_pio),
	.mode_mwdma(mode_mwdma),
	.mode_udma(mode_udma),
	.timing_index(timing_index)
);

// ==========================================
// read channel

reg [31:0] rd_mux;
wire hrst_flag;

assign hrst_flag = hrst_busy || hrst_start_r;

always @* begin
	rd_mux = 32'h00000000;
	if (s_axi_araddr == `CFG_ADDR) begin
		rd_mux = cfg_cur;
		rd_mux[`POS_HARD_RST] = hrst_flag;
	end else if (s_axi_araddr == `STAT_ADDR) begin
		rd_mux[`POS_ST_BUSY] = hrst_flag;
		rd_mux[`POS_ST_VALID] = cfg_valid;
		rd_mux[`POS_ST_REFUSED] = refused_r;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `RESP_OKAY;
	end else begin
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= (s_axi_araddr == `CFG_ADDR || s_axi_araddr == `STAT_ADDR) ?
				`RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule
`default_nettype wire

/* hw/ata_cfg_defs.vh */
// Purpose: constants for the drive interface configuration block
// Assumes: register bit n, numbered msb-first, sits on bus data bit 31-n
// Notes: definitions only
`ifndef ATA_CFG_DEFS_VH
`define ATA_CFG_DEFS_VH

// ==========================================
// register map
`define ADDR_W 8
`define CFG_ADDR 8'h28
`define STAT_ADDR 8'h40
`define CFG_RESET 32'h00000000

// ==========================================
// configuration register fields (bus bit positions)
`define POS_DEV_TYPE 31
`define POS_TM_HI 29
`define POS_TM_LO 28
`define POS_DMA_HI 22
`define POS_DMA_LO 20
`define POS_PIO_HI 18
`define POS_PIO_LO 16
`define POS_SOFT_RST 15
`define POS_HARD_RST 14
`define POS_DIR 12
`define POS_AUTO_CMD 10
`define POS_TRIGGER 9
`define POS_NONDATA 8

// ==========================================
// status register fields
`define POS_ST_BUSY 0
`define POS_ST_VALID 1
`define POS_ST_REFUSED 2

// ==========================================
// mode codes and speed limits
`define TM_PIO 2'h0
`define TM_MWDMA 2'h1
`define TM_RSVD 2'h2
`define TM_UDMA 2'h3
`define MWDMA_MAX 3'h2
`define UDMA_MAX 3'h4
`define PIO_MAX 3'h4

// ==========================================
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ==========================================
// timing
`define CLK_PERIOD_NS 10
`define US_NS 1000
`define HRST_PULSE_US 25
`define TICK_CYCLES (`US_NS / `CLK_PERIOD_NS)

`endif

/* hw/hard_reset_pulse.v */
// Purpose: timed active-low reset pulse toward the drive
// Assumes: start is a one-cycle pulse on aclk
// Notes: pulse length is PULSE_US ticks of a 1 us enable
`timescale 1ns/1ps
`default_nettype none
`include "ata_cfg_defs.vh"

module hard_reset_pulse #(
	parameter integer TICK_CYCLES = `TICK_CYCLES,
	parameter integer PULSE_US = `HRST_PULSE_US
) (
	input wire aclk,
	input wire aresetn,
	input wire start,
	output reg busy,
	output reg drive_reset_n
);

// ==========================================
// 1 us enable divider, restarted at pulse start so length is exact
reg [7:0] div_r;
reg [7:0] us_r;
wire tick;

assign tick = (div_r == TICK_CYCLES[7:0] - 8'h01);

always @(posedge aclk) begin
	if (!aresetn) begin
		div_r <= 8'h00;
		us_r <= 8'h00;
		busy <= 1'b0;
		drive_reset_n <= 1'b1;
	end else if (start && !busy) begin
		div_r <= 8'h00;
		us_r <= 8'h00;
		busy <= 1'b1;
		drive_reset_n <= 1'b0;
	end else if (busy) begin
		div_r <= tick ? 8'h00 : div_r + 8'h01;
		if (tick) begin
			if (us_r == PULSE_US[7:0] - 8'h01) begin
				busy <= 1'b0;
				drive_reset_n <= 1'b1;
			end
			us_r <= us_r + 8'h01;
		end
	end
end

endmodule
`default_nettype wire

/* hw/speed_decode.v */
// Purpose: registered decode of transfer mode and speed grade
// Assumes: inputs are the stored configuration fields
// Notes: reserved codes give timing index 0; only the reserved mode code gives no mode
`timescale 1ns/1ps
`default_nettype none
`include "ata_cfg_defs.vh"

module speed_decode (
	input wire aclk,
	input wire aresetn,
	input wire [1:0] transfer_mode_code,
	input wire [2:0] dma_speed_sel,
	input wire [2:0] pio_speed_sel,
	output reg mode_pio,
	output reg mode_mwdma,
	output reg mode_udma,
	output reg [2:0] timing_index
);

// ultra dma grade table: 0 and 1 share mode 0, then one step per code
function [2:0] udma_grade;
	input [2:0] code;
	begin
		udma_grade = (code == 3'h0) ? 3'h0 : code - 3'h1;
	end
endfunction

always @(posedge aclk) begin
	if (!aresetn) begin
		mode_pio <= 1'b1;
		mode_mwdma <= 1'b0;
		mode_udma <= 1'b0;
		timing_index <= 3'h0;
	end else begin
		mode_pio <= (transfer_mode_code == `TM_PIO);
		mode_mwdma <= (transfer_mode_code == `TM_MWDMA);
		mode_udma <= (transfer_mode_code == `TM_UDMA);
		case (transfer_mode_code)
		`TM_PIO: begin
			timing_index <= (pio_speed_sel <= `PIO_MAX) ? pio_speed_sel : 3'h0;
		end
		`TM_MWDMA: begin
			timing_index <= (dma_speed_sel <= `MWDMA_MAX) ? dma_speed_sel : 3'h0;
		end
		`TM_UDMA: begin
			timing_index <= (dma_speed_sel <= `UDMA_MAX) ? udma_grade(dma_speed_sel) : 3'h0;
		end
		default: begin
			timing_index <= 3'h0;
		end
		endcase
	end
end

endmodule
`default_nettype wire

/* bench/ata_drive_model.sv */
// Purpose: drive side model that watches the reset pin
// Assumes: drive_reset_n is active low, one clock
// Notes: counts pulses and keeps the last pulse length
`timescale 1ns/1ps
`default_nettype none
module ata_drive_model (
	input wire logic aclk,
	input wire logic drive_reset_n,
	output logic [15:0] pulses,
	output logic [15:0] last_len
);
	logic [15:0] run_r;
	initial begin
		pulses = 16'h0000;
		last_len = 16'h0000;
		run_r = 16'h0000;
	end
	// ==========
	// a real drive only reacts to the low level, so measure that
	always @(posedge aclk) begin
		if (!drive_reset_n) begin
			run_r <= run_r + 16'h1;
		end else if (run_r != 16'h0) begin
			pulses <= pulses + 16'h1;
			last_len <= run_r;
			run_r <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

/* bench/ata_interface_config_assertions.sv */
// Purpose: port checks for the drive interface configuration block
// Assumes: one clock, synchronous active-low reset
// Notes: pulse length is TICK_CYCLES*PULSE_US cycles
`timescale 1ns/1ps
`default_nettype none
module ata_cfg_checker #(
	parameter integer TICK_CYCLES = 100,
	parameter integer PULSE_US = 25
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic device_type_select,
	input wire logic [1:0] transfer_mode_code,
	input wire logic [2:0] dma_speed_sel,
	input wire logic [2:0] pio_speed_sel,
	input wire logic mode_pio,
	input wire logic mode_mwdma,
	input wire logic mode_udma,
	input wire logic [2:0] timing_index,
	input wire logic controller_soft_reset,
	input wire logic drive_reset_n,
	input wire logic seq_start,
	input wire logic seq_cmd_phase,
	input wire logic seq_packet_phase
);
	localparam int PULSE = TICK_CYCLES * PULSE_US;
	int low_cnt;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========
	// counter instead of a long repetition
	always @(posedge aclk) begin
		if (!aresetn || drive_reset_n) low_cnt <= 0;
		else low_cnt <= low_cnt + 1;
	end
	a_trig_single: assert property (seq_start |=> !seq_start)
		else $error("trigger pulse longer than one cycle");
	a_trig_after_wr: assert property ($rose(seq_start) |-> s_axi_bvalid)
		else $error("trigger without a write");
	a_pkt_atapi: assert property (seq_start && seq_packet_phase |-> seq_cmd_phase && device_type_select)
		else $error("packet phase without command phase or atapi");
	a_rsvd_mode: assert property (transfer_mode_code == 2'h2 |=> !(mode_pio || mode_mwdma || mode_udma))
		else $error("reserved mode decoded");
	a_mw_speed: assert property (transfer_mode_code == 2'h1 && dma_speed_sel <= 3'h2 |=> timing_index == $past(dma_speed_sel))
		else $error("multiword speed wrong");
	a_udma_speed: assert property (transfer_mode_code == 2'h3 && dma_speed_sel == 3'h3 |=> timing_index == 3'h2)
		else $error("ultra speed wrong");
	a_pio_speed: assert property (transfer_mode_code == 2'h0 && pio_speed_sel <= 3'h4 |=> timing_index == $past(pio_speed_sel))
		else $error("pio speed wrong");
	a_hrst_len: assert property ($rose(drive_reset_n) |-> low_cnt == PULSE)
		else $error("drive reset pulse length wrong");
	a_hrst_cause: assert property ($fell(drive_reset_n) |-> $past(s_axi_bvalid))
		else $error("drive reset without a write");
	a_reset_vals: assert property ($rose(aresetn) |-> !device_type_select && transfer_mode_code == 2'h0 && !controller_soft_reset && drive_reset_n && mode_pio)
		else $error("reset values wrong");
	c_trig: cover property ($rose(seq_start));
	c_pulse: cover property ($rose(drive_reset_n));
	c_udma: cover property (mode_udma);
endmodule
bind ata_interface_config ata_cfg_checker #(.TICK_CYCLES(TICK_CYCLES), .PULSE_US(PULSE_US)) chk_i (
	.aclk, .aresetn, .s_axi_bvalid, .device_type_select, .transfer_mode_code,
	.dma_speed_sel, .pio_speed_sel, .mode_pio, .mode_mwdma, .mode_udma, .timing_index,
	.controller_soft_reset, .drive_reset_n, .seq_start, .seq_cmd_phase, .seq_packet_phase);
`default_nettype wire

/* bench/ata_interface_config_tb.sv */
// Purpose: self-checking bench for the configuration register
// Assumes: AXI4-Lite master tasks, short hard-reset pulse
// Notes: pulse is TICK*PUS cycles
`timescale 1ns/1ps
`default_nettype none
`include "ata_cfg_defs.vh"
module ata_interface_config_tb;
	localparam int TICK = 4;
	localparam int PUS = 3;
	logic aclk = 1'h0;
	logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, transfer_mode_code;
	logic device_type_select, mode_pio, mode_mwdma, mode_udma, controller_soft_reset;
	logic drive_reset_n, transfer_dir, seq_start, seq_cmd_phase, seq_packet_phase;
	logic seq_data_phase;
	logic [2:0] dma_speed_sel, pio_speed_sel, timing_index, ph;
	logic [15:0] pulses, last_len;
	int mismatches = 0;
	int samples_checked = 0;
	int starts = 0;
	ata_interface_config #(.TICK_CYCLES(TICK), .PULSE_US(PUS)) uut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .device_type_select,
		.transfer_mode_code, .dma_speed_sel, .pio_speed_sel, .mode_pio, .mode_mwdma,
		.mode_udma, .timing_index, .controller_soft_reset, .drive_reset_n, .transfer_dir,
		.seq_start, .seq_cmd_phase, .seq_packet_phase, .seq_data_phase);
	ata_drive_model drv (.aclk, .drive_reset_n, .pulses, .last_len);
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		if (seq_start) begin
			starts <= starts + 1;
			ph <= {seq_cmd_phase, seq_packet_phase, seq_data_phase};
		end
	end
	// ==========
	// bus tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		// the loop test sees the values from before this edge's assignments
		do begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bready <= 1'h0;
				r = s_axi_bresp;
			end
		end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rready <= 1'h0;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
		end while (s_axi_arvalid || s_axi_rready);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_fields();
		rd(`CFG_ADDR);
		chk(d, `CFG_RESET);
		chk({mode_pio, drive_reset_n, seq_start}, 3'h6);
		wr(`CFG_ADDR, 32'hFFFF_BDFF, 4'hF);
		rd(`CFG_ADDR);
		chk(d, 32'hB077_9100);
		chk({device_type_select, transfer_dir, controller_soft_reset}, 3'h7);
		wr(`CFG_ADDR, 32'h0000_0000, 4'h1);
		rd(`CFG_ADDR);
		chk(d, 32'hB077_9100);
		wr(`CFG_ADDR, 32'h0000_0000, 4'hF);
		chk({device_type_select, transfer_dir, controller_soft_reset}, 3'h0);
		wr(8'h2C, 32'hFFFF_FFFF, 4'hF);
		chk(r, `RESP_SLVERR);
		rd(8'h2C);
		chk(d, 32'h0000_0000);
		chk(r, `RESP_SLVERR);
	endtask
	task automatic t_modes();
		// code, speed, flags pio/mw/udma (7 = not judged), timing
		logic [10:0] t [0:10] = '{{2'h0, 3'h4, 3'h4, 3'h4}, {2'h0, 3'h2, 3'h4, 3'h2},
			{2'h1, 3'h2, 3'h2, 3'h2}, {2'h1, 3'h0, 3'h2, 3'h0}, {2'h3, 3'h4, 3'h1, 3'h3},
			{2'h3, 3'h2, 3'h1, 3'h1}, {2'h3, 3'h1, 3'h1, 3'h0}, {2'h2, 3'h1, 3'h0, 3'h0},
			{2'h0, 3'h5, 3'h7, 3'h0}, {2'h1, 3'h3, 3'h7, 3'h0}, {2'h3, 3'h5, 3'h7, 3'h0}};
		for (int i = 0; i < 11; i++) begin
			wr(`CFG_ADDR, {2'h0, t[i][10:9], 5'h0, t[i][8:6], 1'h0, t[i][8:6], 16'h0}, 4'hF);
			chk(timing_index, t[i][2:0]);
			if (t[i][5:3] != 3'h7) chk({mode_pio, mode_mwdma, mode_udma}, t[i][5:3]);
		end
	endtask
	task automatic t_hard();
		logic [15:0] p0;
		p0 = pulses;
		wr(`CFG_ADDR, 32'h0000_4000, 4'h2);
		rd(`CFG_ADDR);
		chk(d[14], 1'h1);
		for (int i = 0; i < 200 && pulses == p0; i++) @(posedge aclk);
		chk(pulses, p0 + 16'h1);
		chk(last_len, TICK * PUS);
		rd(`CFG_ADDR);
		chk(d[14], 1'h0);
	endtask
	task automatic t_trig();
		int s0;
		s0 = starts;
		// firmware loads type and mode in the same write that sets the trigger
		wr(`CFG_ADDR, 32'h8000_0600, 4'hF);
		@(posedge aclk);
		chk(starts, s0 + 1);
		chk(ph, 3'h7);
		rd(`CFG_ADDR);
		chk(d, 32'h8000_0000);
		wr(`CFG_ADDR, 32'h0000_0300, 4'hF);
		@(posedge aclk);
		chk(ph, 3'h0);
		wr(`CFG_ADDR, 32'h2000_0200, 4'hF);
		@(posedge aclk);
		chk(starts, s0 + 2);
		rd(`STAT_ADDR);
		chk(d, 32'h0000_0004);
		wr(`STAT_ADDR, 32'h0000_0004, 4'h1);
		rd(`STAT_ADDR);
		chk(d, 32'h0000_0000);
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		t_fields();
		t_modes();
		t_hard();
		t_trig();
		test_done();
	end
	initial begin
		#100000;
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire
